// File: shared/refresh_link_pkg.sv
// constants, command codes and strobe window tables for the refresh link
// assumes both ends compile this package first
package refresh_link_pkg;
  localparam int CA_W = 6;
  localparam int OP_W = 5;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int CNT_W = 8;
  localparam int SEL_ALL_BIT = 5;
  localparam logic [BANK_W-1:0] LAST_BANK = 3'h7;
  localparam logic [OP_W-1:0] OP_REFRESH = 5'h08;
  localparam logic [OP_W-1:0] OP_WRITE = 5'h04;
  localparam logic [OP_W-1:0] OP_MASKED_WRITE = 5'h0C;
  localparam logic [OP_W-1:0] OP_READ = 5'h02;
  typedef enum logic [2:0] {
    REQ_WRITE, REQ_MASKED_WRITE, REQ_READ, REQ_REF_BANK, REQ_REF_ALL,
    REQ_SR_ENTER, REQ_SR_EXIT
  } req_kind_e;
  //////////////////////////////////////////////////////////////////////
  // latency set A and B, top clock band
  localparam int WRITE_LATENCY_A = 18;
  localparam int WRITE_LATENCY_B = 34;
  localparam int READ_LATENCY_A = 36;
  localparam int READ_LATENCY_B = 40;
  localparam int STROBE_ON_A = 8;
  localparam int STROBE_ON_B = 24;
  localparam int STROBE_OFF_A = 36;
  localparam int STROBE_OFF_B = 52;
  localparam int BURST_HALF = 8;
  localparam int READ_POSTAMBLE_CLKS = 1;
  localparam int WRITE_PREAMBLE_CLKS = 2;
  localparam int STROBE_TURNAROUND_CLKS = 1;
  localparam int READ_GAP_EXTRA = 0;
  //////////////////////////////////////////////////////////////////////
  // link clock made by the controller from clk_sys
  localparam int CLK_SYS_NS = 100;
  localparam int CK_HALF_SYS = 1;
  localparam int CK_NS = 2 * CK_HALF_SYS * CLK_SYS_NS;
  localparam int REFRESH_BANK_NS = 280;
  localparam int REFRESH_BANK_CLKS = (REFRESH_BANK_NS + CK_NS - 1) / CK_NS;

  function automatic logic [CNT_W-1:0] strobe_on(input logic set_b);
    strobe_on = CNT_W'(set_b ? STROBE_ON_B : STROBE_ON_A);
  endfunction : strobe_on

  function automatic logic [CNT_W-1:0] strobe_off(input logic set_b);
    strobe_off = CNT_W'(set_b ? STROBE_OFF_B : STROBE_OFF_A);
  endfunction : strobe_off

  // turnaround only feeds this period and nothing else
  function automatic logic [CNT_W-1:0] strobe_exception_period(input logic set_b,
                                                             input logic term_on);
    int v;
    v = (set_b ? WRITE_LATENCY_B : WRITE_LATENCY_A) - int'(strobe_on(set_b))
        + STROBE_TURNAROUND_CLKS - WRITE_PREAMBLE_CLKS - READ_GAP_EXTRA;
    if (term_on) v = STROBE_TURNAROUND_CLKS;
    if (v < 0) v = 0;
    strobe_exception_period = CNT_W'(v);
  endfunction : strobe_exception_period

  // read burst, postamble and turnaround during which the strobe is waived
  function automatic logic [CNT_W-1:0] read_window(input logic set_b, input logic term_on);
    read_window = CNT_W'((set_b ? READ_LATENCY_B : READ_LATENCY_A) + BURST_HALF
        + READ_POSTAMBLE_CLKS + int'(strobe_exception_period(set_b, term_on)));
  endfunction : read_window
endpackage : refresh_link_pkg

// File: shared/refresh_link_if.sv
// command link between memory controller and memory device
// assumes the controller end drives every signal, the device only listens
`timescale 1ns/10ps
interface refresh_link_if;
  logic ck;
  logic cs;
  logic [refresh_link_pkg::CA_W-1:0] ca;
  logic cke;
  logic reset_n;
  logic strobe_diff;
  logic mode_set_b;
  logic mode_term_on;
  modport ctl (output ck, cs, ca, cke, reset_n, strobe_diff, mode_set_b, mode_term_on);
  modport dev (input ck, cs, ca, cke, reset_n, strobe_diff, mode_set_b, mode_term_on);
endinterface : refresh_link_if

// File: rtl/dram_refresh_ctl.sv
// controller end: makes the link clock, encodes commands, drives the strobe
// assumes one request at a time on the user side, all in clk_sys
`timescale 1ns/10ps
module dram_refresh_ctl (
  input wire logic clk_sys,
  input wire logic rst,
  refresh_link_if.ctl link,
  input wire logic req_valid,
  input wire refresh_link_pkg::req_kind_e req_kind,
  input wire logic [refresh_link_pkg::BANK_W-1:0] req_bank,
  input wire logic set_b,
  input wire logic term_on,
  input wire logic dram_reset,
  output logic req_ready,
  output logic req_refused
);
  typedef enum logic [1:0] {C_IDLE, C_FIRST, C_SECOND} cphase_e;
  typedef struct packed {
    logic [7:0] div;
    logic ck;
    cphase_e phase;
    refresh_link_pkg::req_kind_e kind;
    logic [refresh_link_pkg::BANK_W-1:0] bank;
    logic cs;
    logic [refresh_link_pkg::CA_W-1:0] ca;
    logic cke;
    logic reset_n;
    logic [refresh_link_pkg::CNT_W-1:0] off_cnt;
    logic strobe_diff;
    logic set_b;
    logic term_on;
    logic [refresh_link_pkg::NUM_BANKS-1:0] refreshed;
    logic ready;
    logic refused;
  } ctl_s;
  ctl_s cur;
  ctl_s next_cur;
  logic ck_fall;
  logic [refresh_link_pkg::OP_W-1:0] op;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur = cur;
    next_cur.refused = 1'b0;
    op = refresh_link_pkg::OP_WRITE;
    ck_fall = cur.ck && (cur.div == 8'(refresh_link_pkg::CK_HALF_SYS - 1));
    // divider: the link clock is derived, not a second domain here
    if (cur.div == 8'(refresh_link_pkg::CK_HALF_SYS - 1)) begin
      next_cur.div = 8'h00;
      next_cur.ck = ~cur.ck;
    end else begin
      next_cur.div = cur.div + 8'h01;
    end
    next_cur.reset_n = ~dram_reset;
    if (dram_reset) begin
      next_cur.refreshed = '0;
    end
    // take a request; a repeated bank within the set is refused
    if (req_valid && cur.ready) begin
      next_cur.ready = 1'b0;
      next_cur.kind = req_kind;
      next_cur.bank = req_bank;
      next_cur.phase = C_FIRST;
      if ((req_kind == refresh_link_pkg::REQ_REF_BANK && cur.refreshed[req_bank])
          || (!cur.cke && req_kind != refresh_link_pkg::REQ_SR_EXIT)) begin
        next_cur.refused = 1'b1;
        next_cur.ready = 1'b1;
        next_cur.phase = C_IDLE;
      end
    end
    // pins change on the falling link edge, device samples on the rising one
    if (ck_fall) begin
      if (cur.off_cnt != '0) begin
        next_cur.off_cnt = cur.off_cnt - 1'b1;
      end
      next_cur.strobe_diff = (next_cur.off_cnt != '0);
      next_cur.cs = 1'b0;
      next_cur.ca = '0;
      case (cur.phase)
        C_FIRST: begin
          next_cur.set_b = set_b;
          next_cur.term_on = term_on;
          next_cur.phase = C_SECOND;
          case (cur.kind)
            refresh_link_pkg::REQ_WRITE: op = refresh_link_pkg::OP_WRITE;
            refresh_link_pkg::REQ_MASKED_WRITE: op = refresh_link_pkg::OP_MASKED_WRITE;
            refresh_link_pkg::REQ_READ: op = refresh_link_pkg::OP_READ;
            default: op = refresh_link_pkg::OP_REFRESH;
          endcase
          next_cur.cs = 1'b1;
          next_cur.ca = {cur.kind == refresh_link_pkg::REQ_REF_ALL, op};
          if (cur.kind == refresh_link_pkg::REQ_WRITE
              || cur.kind == refresh_link_pkg::REQ_MASKED_WRITE) begin
            // strobe on at once, well inside the on deadline; one spare clock
            // covers the half period between pin change and device sample
            next_cur.off_cnt = refresh_link_pkg::strobe_off(set_b) + 1'b1;
            next_cur.strobe_diff = 1'b1;
          end
          if (cur.kind == refresh_link_pkg::REQ_SR_ENTER
              || cur.kind == refresh_link_pkg::REQ_SR_EXIT) begin
            next_cur.cs = 1'b0;
            next_cur.ca = '0;
            next_cur.cke = (cur.kind == refresh_link_pkg::REQ_SR_EXIT);
            next_cur.phase = C_IDLE;
            next_cur.ready = 1'b1;
            if (cur.kind == refresh_link_pkg::REQ_SR_EXIT) begin
              next_cur.refreshed = '0;
            end
          end
        end
        C_SECOND: begin
          next_cur.ca = {3'h0, cur.bank};
          next_cur.phase = C_IDLE;
          next_cur.ready = 1'b1;
          if (cur.kind == refresh_link_pkg::REQ_REF_ALL) begin
            next_cur.refreshed = '0;
          end else if (cur.kind == refresh_link_pkg::REQ_REF_BANK) begin
            next_cur.refreshed[cur.bank] = 1'b1;
            if ((cur.refreshed | (8'h01 << cur.bank)) == 8'hFF) begin
              next_cur.refreshed = '0;
            end
          end
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur <= '{div: 8'h00, ck: 1'b0, phase: C_IDLE, kind: refresh_link_pkg::REQ_WRITE,
               bank: 3'h0, cs: 1'b0, ca: 6'h00, cke: 1'b1, reset_n: 1'b0,
               off_cnt: 8'h00, strobe_diff: 1'b0, set_b: 1'b0, term_on: 1'b0,
               refreshed: 8'h00, ready: 1'b1, refused: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign link.ck = cur.ck;
  assign link.cs = cur.cs;
  assign link.ca = cur.ca;
  assign link.cke = cur.cke;
  assign link.reset_n = cur.reset_n;
  assign link.strobe_diff = cur.strobe_diff;
  assign link.mode_set_b = cur.set_b;
  assign link.mode_term_on = cur.term_on;
  assign req_ready = cur.ready;
  assign req_refused = cur.refused;
endmodule : dram_refresh_ctl

// File: rtl/dram_refresh_dev.sv
// device end: decodes refresh commands, keeps bank and row counters,
// watches the write strobe window
// assumes every link pin except reset_n changes on the falling ck edge
`timescale 1ns/10ps
// Functional notes
// - strobe differential by on delay after write
// - strobe held until off delay after write
// - read burst and turnaround waive strobe window
// - toggling during bursts counts as differential
// - strobe windows add no command spacing
// - exception period from termination and latencies
// - strobe edges may move quarter clock
// - turnaround used only in exception period
// - refresh opcode on first edge, bit5 selects all
// - single-bank target bank on second edge
// - banks within a set in any order
// - no bank twice within one set
// - set counting starts after synchronisation
// - reset and self-refresh exit clear bank counter
// - all-bank refresh clears bank counter
// - all-bank or self refresh allowed mid-set
// - all-bank refresh uses current row, clears count
// - next refresh after all-bank uses row+1
// - controller refreshes only idle, tracked banks; the controller here tracks the set but not bank busy
// - only the refreshed bank is busy meanwhile
module dram_refresh_dev #(
  parameter int ROW_W = 16
) (
  input wire logic rst,
  refresh_link_if.dev link,
  output logic refresh_pulse,
  output logic refresh_all,
  output logic [refresh_link_pkg::BANK_W-1:0] refresh_bank,
  output logic [ROW_W-1:0] refresh_row,
  output logic [refresh_link_pkg::BANK_W-1:0] bank_count,
  output logic [ROW_W-1:0] row_count,
  output logic [refresh_link_pkg::NUM_BANKS-1:0] bank_busy,
  output logic write_pulse,
  output logic read_pulse,
  output logic order_fault,
  output logic strobe_fault
);
  typedef enum logic [1:0] {D_IDLE, D_REF_SECOND, D_CMD_SECOND} dphase_e;
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic cke_prev;
    dphase_e phase;
    logic pend_all;
    logic [refresh_link_pkg::BANK_W-1:0] bank_cnt;
    logic [ROW_W-1:0] row_cnt;
    logic [refresh_link_pkg::NUM_BANKS-1:0] refreshed;
    logic [refresh_link_pkg::NUM_BANKS-1:0][refresh_link_pkg::CNT_W-1:0] busy_cnt;
    logic [refresh_link_pkg::NUM_BANKS-1:0] busy;
    logic [refresh_link_pkg::CNT_W-1:0] on_cnt;
    logic [refresh_link_pkg::CNT_W-1:0] off_cnt;
    logic [refresh_link_pkg::CNT_W-1:0] read_win;
    logic ref_pulse;
    logic ref_all;
    logic [refresh_link_pkg::BANK_W-1:0] ref_bank;
    logic [ROW_W-1:0] ref_row;
    logic wr_pulse;
    logic rd_pulse;
    logic order_fault;
    logic strobe_fault;
  } dev_s;
  dev_s cur;
  dev_s next_cur;
  logic [refresh_link_pkg::OP_W-1:0] op;
  logic [refresh_link_pkg::BANK_W-1:0] tgt;

  function automatic logic is_write(input logic [refresh_link_pkg::OP_W-1:0] code);
    is_write = (code == refresh_link_pkg::OP_WRITE)
               || (code == refresh_link_pkg::OP_MASKED_WRITE);
  endfunction : is_write

  function automatic logic is_known(input logic [refresh_link_pkg::OP_W-1:0] code);
    is_known = is_write(code) || (code == refresh_link_pkg::OP_READ)
               || (code == refresh_link_pkg::OP_REFRESH);
  endfunction : is_known

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur = cur;
    op = link.ca[refresh_link_pkg::OP_W-1:0];
    tgt = link.ca[refresh_link_pkg::BANK_W-1:0];
    next_cur.ref_pulse = 1'b0;
    next_cur.wr_pulse = 1'b0;
    next_cur.rd_pulse = 1'b0;
    // reset pin is asynchronous to ck: two stages before use
    next_cur.rst_meta = ~link.reset_n;
    next_cur.rst_sync = cur.rst_meta;
    next_cur.cke_prev = link.cke;

    // busy timers: the other banks stay usable
    for (int b = 0; b < refresh_link_pkg::NUM_BANKS; b++) begin
      if (cur.busy_cnt[b] != '0) begin
        next_cur.busy_cnt[b] = cur.busy_cnt[b] - 1'b1;
      end
      next_cur.busy[b] = (next_cur.busy_cnt[b] != '0);
    end

    // strobe window watch; the fault is sticky until reset
    if (cur.on_cnt != '0) begin
      next_cur.on_cnt = cur.on_cnt - 1'b1;
    end
    if (cur.off_cnt != '0) begin
      next_cur.off_cnt = cur.off_cnt - 1'b1;
    end
    if (cur.read_win != '0) begin
      next_cur.read_win = cur.read_win - 1'b1;
    end
    // a toggling burst shows as differential, so it satisfies the window
    if (cur.off_cnt != '0 && cur.on_cnt == '0 && !link.strobe_diff
        && cur.read_win == '0) begin
      next_cur.strobe_fault = 1'b1;
    end

    if (cur.rst_sync) begin
      next_cur.bank_cnt = '0;
      next_cur.refreshed = '0;
      next_cur.phase = D_IDLE;
    end else if (!cur.cke_prev && link.cke) begin
      // self refresh exit resynchronises the count
      next_cur.bank_cnt = '0;
      next_cur.refreshed = '0;
      next_cur.phase = D_IDLE;
    end else if (!link.cke) begin
      // self refresh: commands are not decoded
      next_cur.phase = D_IDLE;
    end else begin
      case (cur.phase)
        D_IDLE: begin
          if (link.cs && op == refresh_link_pkg::OP_REFRESH) begin
            next_cur.pend_all = link.ca[refresh_link_pkg::SEL_ALL_BIT];
            next_cur.phase = D_REF_SECOND;
          end else if (link.cs && is_known(op)) begin
            next_cur.phase = D_CMD_SECOND;
            if (is_write(op)) begin
              // windows only watch, they never hold off a command
              next_cur.wr_pulse = 1'b1;
              next_cur.on_cnt = refresh_link_pkg::strobe_on(link.mode_set_b);
              next_cur.off_cnt = refresh_link_pkg::strobe_off(link.mode_set_b);
            end else begin
              next_cur.rd_pulse = 1'b1;
              next_cur.read_win = refresh_link_pkg::read_window(link.mode_set_b,
                                                                link.mode_term_on);
            end
          end
        end
        D_REF_SECOND: begin
          next_cur.phase = D_IDLE;
          next_cur.ref_pulse = 1'b1;
          next_cur.ref_all = cur.pend_all;
          next_cur.ref_row = cur.row_cnt;
          if (cur.pend_all) begin
            // legal at any point of a set
            next_cur.ref_bank = '0;
            next_cur.bank_cnt = '0;
            next_cur.refreshed = '0;
            next_cur.row_cnt = cur.row_cnt + 1'b1;
            for (int b = 0; b < refresh_link_pkg::NUM_BANKS; b++) begin
              next_cur.busy_cnt[b] = refresh_link_pkg::CNT_W'(refresh_link_pkg::REFRESH_BANK_CLKS);
              next_cur.busy[b] = 1'b1;
            end
          end else begin
            next_cur.ref_bank = tgt;
            // any order is fine, a repeat inside the set is flagged
            if (cur.refreshed[tgt] || cur.busy[tgt]) begin
              next_cur.order_fault = 1'b1;
            end
            next_cur.refreshed[tgt] = 1'b1;
            next_cur.busy_cnt[tgt] =
              refresh_link_pkg::CNT_W'(refresh_link_pkg::REFRESH_BANK_CLKS);
            next_cur.busy[tgt] = 1'b1;
            next_cur.bank_cnt = cur.bank_cnt + 1'b1;
            if (cur.bank_cnt == refresh_link_pkg::LAST_BANK) begin
              next_cur.row_cnt = cur.row_cnt + 1'b1;
              next_cur.refreshed = '0;
            end
          end
        end
        D_CMD_SECOND: begin
          // second edge of read or write carries nothing watched here
          next_cur.phase = D_IDLE;
        end
        default: next_cur.phase = D_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // logic facing the link runs on the link's own clock
  always_ff @(posedge link.ck or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.rst_meta <= 1'b1;
      cur.rst_sync <= 1'b1;
      cur.cke_prev <= 1'b1;
      cur.phase <= D_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  assign refresh_pulse = cur.ref_pulse;
  assign refresh_all = cur.ref_all;
  assign refresh_bank = cur.ref_bank;
  assign refresh_row = cur.ref_row;
  assign bank_count = cur.bank_cnt;
  assign row_count = cur.row_cnt;
  assign bank_busy = cur.busy;
  assign write_pulse = cur.wr_pulse;
  assign read_pulse = cur.rd_pulse;
  assign order_fault = cur.order_fault;
  assign strobe_fault = cur.strobe_fault;
endmodule : dram_refresh_dev

// File: sim/dram_refresh_and_write_strobe_monitor.sv
// checker on the controller-to-device link and the device's refresh outputs
// assumes ck comes from the controller end and rst is async, active high
`timescale 1ns/10ps
module dram_refresh_and_write_strobe_monitor #(
  parameter int ROW_W = 16
) (
  input wire logic ck,
  input wire logic rst,
  input wire logic cs,
  input wire logic [5:0] ca,
  input wire logic cke,
  input wire logic strobe_diff,
  input wire logic mode_set_b,
  input wire logic refresh_pulse,
  input wire logic refresh_all,
  input wire logic [2:0] refresh_bank,
  input wire logic [ROW_W-1:0] refresh_row,
  input wire logic [2:0] bank_count,
  input wire logic [ROW_W-1:0] row_count,
  input wire logic [7:0] bank_busy
);
  typedef struct packed {
    logic [7:0] off_cnt;
  } mon_s;
  mon_s st;
  mon_s next_st;
  logic wr_cmd;
  logic ref_cmd;
  assign wr_cmd = cs && cke && (ca[4:0] == 5'h04 || ca[4:0] == 5'h0C);
  assign ref_cmd = cs && cke && ca[4:0] == refresh_link_pkg::OP_REFRESH;
  // off window counted from the last write; the set is read at the write itself
  always_comb begin
    next_st = st;
    if (wr_cmd) begin
      next_st.off_cnt = mode_set_b ? 8'h34 : 8'h24;
    end else if (st.off_cnt != 8'h00) begin
      next_st.off_cnt = st.off_cnt - 8'h01;
    end
  end
  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ck); endclocking
  default disable iff (rst);
  property p_strobe_on;
    wr_cmd |-> strobe_diff;
  endproperty
  a_strobe_on: assert property (p_strobe_on) else $error("strobe idle at write");
  property p_strobe_hold;
    st.off_cnt != 8'h00 |-> strobe_diff;
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe dropped early");
  property p_ref_kind;
    ref_cmd |-> ##2 refresh_pulse && refresh_all == $past(ca[5], 2);
  endproperty
  a_ref_kind: assert property (p_ref_kind) else $error("refresh kind wrong");
  property p_ref_bank;
    ref_cmd && !ca[5] |-> ##2 refresh_bank == $past(ca[2:0]);
  endproperty
  a_ref_bank: assert property (p_ref_bank) else $error("refresh bank wrong");
  property p_bank_step;
    refresh_pulse && !refresh_all |-> bank_count == $past(bank_count) + 3'h1;
  endproperty
  a_bank_step: assert property (p_bank_step) else $error("bank count step wrong");
  property p_all_sync;
    refresh_pulse && refresh_all |-> bank_count == 3'h0 && bank_busy == 8'hFF;
  endproperty
  a_all_sync: assert property (p_all_sync) else $error("all-bank sync wrong");
  property p_row_all;
    refresh_pulse && refresh_all |-> refresh_row == $past(row_count)
      && row_count == $past(row_count) + 1'b1;
  endproperty
  a_row_all: assert property (p_row_all) else $error("all-bank row wrong");
  property p_row_set;
    refresh_pulse && !refresh_all |->
      row_count == $past(row_count) + ($past(bank_count) == 3'h7);
  endproperty
  a_row_set: assert property (p_row_set) else $error("row advance wrong");
  property p_busy;
    refresh_pulse && !refresh_all |-> bank_busy[refresh_bank] ##2 !bank_busy[refresh_bank];
  endproperty
  a_busy: assert property (p_busy) else $error("bank busy span wrong");
  property p_sr_sync;
    $rose(cke) |-> ##[1:4] bank_count == 3'h0;
  endproperty
  a_sr_sync: assert property (p_sr_sync) else $error("bank count kept at exit");
endmodule : dram_refresh_and_write_strobe_monitor

// File: sim/dram_refresh_and_write_strobe_tb.sv
// bench: controller and device joined on link; a second device on link2 is fed
// by a careless bench driver; assumes package, interface and both ends compiled
`timescale 1ns/10ps
module dram_refresh_and_write_strobe_tb;
  localparam int ROW_W = 16;
  logic clk_sys, rst, req_valid, set_b, term_on, dram_reset, req_ready, req_refused;
  refresh_link_pkg::req_kind_e req_kind;
  logic [2:0] req_bank, refresh_bank, bank_count, e_bank;
  logic refresh_pulse, refresh_all, write_pulse, read_pulse, in_sr;
  logic order_fault, strobe_fault, order_fault2, strobe_fault2;
  logic [ROW_W-1:0] refresh_row, row_count, e_row;
  logic [7:0] bank_busy, done_mask;
  logic [2:0] ord [8] = '{3'h1, 3'h3, 3'h0, 3'h2, 3'h4, 3'h7, 3'h5, 3'h6};
  int n_fail, compares, n_evt, cyc;
  refresh_link_if link();
  refresh_link_if link2();
  dram_refresh_ctl i_dram_refresh_ctl (.clk_sys, .rst, .link, .req_valid, .req_kind,
    .req_bank, .set_b, .term_on, .dram_reset, .req_ready, .req_refused);
  dram_refresh_dev #(.ROW_W(ROW_W)) i_dram_refresh_dev (.rst, .link, .refresh_pulse,
    .refresh_all, .refresh_bank, .refresh_row, .bank_count, .row_count, .bank_busy,
    .write_pulse, .read_pulse, .order_fault, .strobe_fault);
  dram_refresh_dev #(.ROW_W(ROW_W)) i_dram_refresh_dev_fault (.rst(rst), .link(link2),
    .refresh_pulse(), .refresh_all(), .refresh_bank(), .refresh_row(), .bank_count(),
    .row_count(), .bank_busy(), .write_pulse(), .read_pulse(),
    .order_fault(order_fault2), .strobe_fault(strobe_fault2));
  dram_refresh_and_write_strobe_monitor #(.ROW_W(ROW_W)) i_monitor (.ck(link.ck), .rst,
    .cs(link.cs), .ca(link.ca), .cke(link.cke), .strobe_diff(link.strobe_diff),
    .mode_set_b(link.mode_set_b), .refresh_pulse, .refresh_all, .refresh_bank,
    .refresh_row, .bank_count, .row_count, .bank_busy);
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    link2.ck = 1'b0;
    #7;
    forever #15 link2.ck = ~link2.ck;
  end
  // counted away from the launching edge so the pulse is settled when read
  always @(negedge link.ck) begin
    if (refresh_pulse === 1'b1 || write_pulse === 1'b1 || read_pulse === 1'b1) begin
      n_evt <= n_evt + 1;
    end
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // link2 pins move on the falling edge; ca is inverted once released
  task automatic cmd2(input logic [5:0] a, input logic [5:0] b);
    @(negedge link2.ck);
    link2.cs <= 1'b1;
    link2.ca <= a;
    @(negedge link2.ck);
    link2.cs <= 1'b0;
    link2.ca <= b;
    @(negedge link2.ck);
    link2.ca <= ~b;
  endtask : cmd2
  task automatic req(input refresh_link_pkg::req_kind_e k, input logic [2:0] b);
    int n;
    int ev;
    logic refused;
    logic no;
    no = (in_sr && k != refresh_link_pkg::REQ_SR_EXIT)
      || (k == refresh_link_pkg::REQ_REF_BANK && done_mask[b]);
    refused = 1'b0;
    ev = n_evt;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_kind <= k;
    req_bank <= b;
    do @(negedge clk_sys); while (req_ready !== 1'b1 && ++n < 100);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    repeat (2) begin
      @(negedge clk_sys);
      refused = refused | (req_refused === 1'b1);
    end
    cmp(16'(refused), 16'(no));
    if (no) return;
    n = 0;
    if (k == refresh_link_pkg::REQ_SR_ENTER || k == refresh_link_pkg::REQ_SR_EXIT) begin
      in_sr = (k == refresh_link_pkg::REQ_SR_ENTER);
      while (link.cke !== !in_sr && n < 50) begin
        @(negedge clk_sys);
        n++;
      end
      cmp(16'(link.cke), 16'(!in_sr));
      if (!in_sr) begin
        e_bank = 3'h0;
        done_mask = 8'h00;
      end
      return;
    end
    while (n_evt == ev && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    cmp(16'(n_evt - ev), 16'h0001);
    if (k == refresh_link_pkg::REQ_REF_BANK || k == refresh_link_pkg::REQ_REF_ALL) begin
      cmp(16'(refresh_all), 16'(k == refresh_link_pkg::REQ_REF_ALL));
      cmp(refresh_row, e_row);
      if (k == refresh_link_pkg::REQ_REF_ALL) begin
        e_bank = 3'h0;
        done_mask = 8'h00;
        e_row++;
      end else begin
        cmp(16'(refresh_bank), 16'(b));
        done_mask[b] = 1'b1;
        e_bank++;
        if (e_bank == 3'h0) begin
          done_mask = 8'h00;
          e_row++;
        end
      end
      cmp(16'(bank_count), 16'(e_bank));
      cmp(row_count, e_row);
    end
  endtask : req
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst, req_valid, set_b, term_on, dram_reset} = 5'h10;
    req_kind = refresh_link_pkg::REQ_READ;
    req_bank = 3'h0;
    {link2.cs, link2.ca, link2.cke, link2.reset_n} = 9'h002;
    {link2.strobe_diff, link2.mode_set_b, link2.mode_term_on} = 3'h0;
    {e_row, e_bank, done_mask, in_sr} = '0;
    {n_fail, compares, n_evt, cyc} = '0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    link2.reset_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    cmd2(6'h08, 6'h01);
    repeat (4) @(negedge link2.ck);
    cmp(16'(order_fault2), 16'h0000);
    cmd2(6'h08, 6'h01);
    repeat (4) @(negedge link2.ck);
    cmp(16'(order_fault2), 16'h0001);
    // a write with an idle strobe inside a read window is waived
    cmd2(6'h02, 6'h00);
    cmd2(6'h04, 6'h00);
    repeat (60) @(negedge link2.ck);
    cmp(16'(strobe_fault2), 16'h0000);
    cmp(16'(strobe_fault2), 16'h0000);
    cmd2(6'h04, 6'h00);
    repeat (60) @(negedge link2.ck);
    cmp(16'(strobe_fault2), 16'h0001);
    $display("careless controller test done");
    foreach (ord[i]) begin
      req(refresh_link_pkg::REQ_REF_BANK, ord[i]);
      if (i == 3) req(refresh_link_pkg::REQ_REF_BANK, 3'h3);
    end
    req(refresh_link_pkg::REQ_REF_BANK, 3'h7);
    req(refresh_link_pkg::REQ_REF_BANK, 3'h1);
    req(refresh_link_pkg::REQ_REF_ALL, 3'h0);
    req(refresh_link_pkg::REQ_REF_BANK, 3'h1);
    $display("refresh set test done");
    req(refresh_link_pkg::REQ_SR_ENTER, 3'h0);
    req(refresh_link_pkg::REQ_REF_BANK, 3'h5);
    req(refresh_link_pkg::REQ_SR_EXIT, 3'h0);
    req(refresh_link_pkg::REQ_REF_BANK, 3'h1);
    $display("self refresh test done");
    // reads kept apart: the strobe may legally drop inside a read window
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      set_b <= i[1];
      term_on <= i[0];
      req(refresh_link_pkg::REQ_WRITE, 3'h0);
      req(refresh_link_pkg::REQ_MASKED_WRITE, 3'h0);
      repeat (120) @(posedge clk_sys);
      cmp(16'(strobe_fault), 16'h0000);
    end
    req(refresh_link_pkg::REQ_READ, 3'h0);
    cmp(16'(order_fault), 16'h0000);
    $display("write strobe test done");
    @(posedge clk_sys);
    dram_reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    dram_reset <= 1'b0;
    repeat (16) @(posedge clk_sys);
    cmp(16'(bank_count), 16'h0000);
    $display("device reset test done");
    conclude();
  end
endmodule : dram_refresh_and_write_strobe_tb
